// *** core/itmr_pkg.sv ***
`default_nettype none
package itmr_pkg;
  // Register map on the 16-bit special function register space
  localparam logic [15:0] MODE_CONTROL_0_ADDR  = 16'hff53;
  localparam logic [15:0] MODE_CONTROL_1_ADDR  = 16'hff57;
  localparam logic [15:0] COMPARE_VALUE_0_ADDR = 16'hff50;
  localparam logic [15:0] COUNTER_0_ADDR       = 16'hff51;
  localparam logic [15:0] COMPARE_VALUE_1_ADDR = 16'hff54;
  localparam logic [15:0] COUNTER_1_ADDR       = 16'hff55;

  // Mode control fields
  localparam int          COUNT_ENABLE_POS    = 7;
  localparam int          CLOCK_SELECT_HI_POS = 2;
  localparam int          CLOCK_SELECT_LO_POS = 1;
  localparam logic [7:0]  MODE_WRITABLE_MASK  = 8'h86;
  localparam logic [7:0]  MODE_CONTROL_RESET  = 8'h00;
  localparam logic [7:0]  COUNTER_RESET       = 8'h00;

  // Prescaler taps: tap k ticks once every 2^(k+1) main clocks
  localparam int          PRESCALE_WIDTH = 7;
  localparam logic [2:0]  TAP_DIV2   = 3'h0;
  localparam logic [2:0]  TAP_DIV4   = 3'h1;
  localparam logic [2:0]  TAP_DIV16  = 3'h3;
  localparam logic [2:0]  TAP_DIV32  = 3'h4;
  localparam logic [2:0]  TAP_DIV64  = 3'h5;
  localparam logic [2:0]  TAP_DIV128 = 3'h6;

  typedef enum logic [1:0] {
    SEL_FAST   = 2'h0,
    SEL_MID    = 2'h1,
    SEL_SLOW   = 2'h2,
    SEL_BANNED = 2'h3
  } clock_select_t;
endpackage
`default_nettype wire

// *** core/prescaler.sv ***
`timescale 1ns/1ns
`default_nettype none
module prescaler
  import itmr_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  output logic [PRESCALE_WIDTH-1:0]      o_phase,
  output logic [PRESCALE_WIDTH-1:0]      o_tick
);
  logic [PRESCALE_WIDTH-1:0] phase_reg;

  // Free running, never cleared by the timers, so a start lands anywhere
  // in the count period
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_reg + 7'h01;
    end
  end

  genvar k;
  generate
    for (k = 0; k < PRESCALE_WIDTH; k++) begin : g_tap
      assign o_tick[k] = &phase_reg[k:0];
    end
  endgenerate

  assign o_phase = phase_reg;
endmodule // prescaler
`default_nettype wire

// *** core/interval_channel.sv ***
`timescale 1ns/1ns
`default_nettype none
module interval_channel
  import itmr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_enable,
  input  wire logic       i_tick,
  input  wire logic [7:0] i_compare,
  output logic [7:0]      o_count,
  output logic            o_match
);
  logic [7:0] count_reg;
  logic       match_reg;
  logic       hit;

  assign hit = (count_reg == i_compare);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= COUNTER_RESET;
    end else if (!i_enable) begin
      count_reg <= COUNTER_RESET;
    end else if (i_tick) begin
      count_reg <= hit ? COUNTER_RESET : count_reg + 8'h01;
    end
  end

  // One main clock wide request per match
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= i_enable && i_tick && hit;
    end
  end

  assign o_count = count_reg;
  assign o_match = match_reg;
endmodule // interval_channel
`default_nettype wire

// *** core/dual_interval_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
module dual_interval_timer
  import itmr_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic [7:0]  i_wr_bits,
  input  wire logic        i_rd,
  output logic [7:0]       o_rd_data,
  output logic             o_match_irq_0,
  output logic             o_match_irq_1
);
  logic [PRESCALE_WIDTH-1:0] phase;
  logic [PRESCALE_WIDTH-1:0] taps;
  logic [7:0]                mode_control_reg [2];
  logic [7:0]                compare_value_reg [2];
  logic [7:0]                counter [2];
  logic                      match_irq [2];
  logic                      count_enable [2];
  logic [1:0]                clock_select [2];
  logic                      count_tick [2];
  logic [7:0]                rd_data_reg;

  // Merge of a byte write or a single-bit write into a register
  function automatic logic [7:0] merge_bits(
    input logic [7:0] old_val,
    input logic [7:0] data,
    input logic [7:0] bits
  );
    merge_bits = (old_val & ~bits) | (data & bits);
  endfunction

  // Picks the count clock enable for a select code
  function automatic logic pick_tick(
    input logic [PRESCALE_WIDTH-1:0] t,
    input logic [2:0]                fast,
    input logic [2:0]                mid,
    input logic [2:0]                slow,
    input logic [1:0]                sel
  );
    case (clock_select_t'(sel))
      SEL_FAST: pick_tick = t[fast];
      SEL_MID:  pick_tick = t[mid];
      SEL_SLOW: pick_tick = t[slow];
      default:  pick_tick = 1'b0;
    endcase
  endfunction

  prescaler u_prescaler (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .o_phase (phase),
    .o_tick  (taps)
  );

  // Barred code gives no count clock, so the counter just holds
  assign count_tick[0] = pick_tick(taps, TAP_DIV4, TAP_DIV16, TAP_DIV64,
                                   clock_select[0]);
  assign count_tick[1] = pick_tick(taps, TAP_DIV2, TAP_DIV32, TAP_DIV128,
                                   clock_select[1]);

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_timer
      localparam logic [15:0] MODE_ADDR =
        (i == 0) ? MODE_CONTROL_0_ADDR : MODE_CONTROL_1_ADDR;
      localparam logic [15:0] CMP_ADDR =
        (i == 0) ? COMPARE_VALUE_0_ADDR : COMPARE_VALUE_1_ADDR;

      // Only enable and clock select are stored; other bits stay zero
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          mode_control_reg[i] <= MODE_CONTROL_RESET;
        end else if (i_wr && i_addr == MODE_ADDR) begin
          mode_control_reg[i] <= merge_bits(mode_control_reg[i],
                                            i_wr_data, i_wr_bits)
                                 & MODE_WRITABLE_MASK;
        end
      end

      // No reset: content after reset is left undefined
      always_ff @(posedge i_clk) begin
        if (i_wr && i_addr == CMP_ADDR) begin
          compare_value_reg[i] <= merge_bits(compare_value_reg[i],
                                             i_wr_data, i_wr_bits);
        end
      end

      assign count_enable[i] = mode_control_reg[i][COUNT_ENABLE_POS];
      assign clock_select[i] =
        mode_control_reg[i][CLOCK_SELECT_HI_POS:CLOCK_SELECT_LO_POS];

      interval_channel u_channel (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_enable  (count_enable[i]),
        .i_tick    (count_tick[i]),
        .i_compare (compare_value_reg[i]),
        .o_count   (counter[i]),
        .o_match   (match_irq[i])
      );
    end
  endgenerate

  // Register read path, one cycle behind the read strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_data_reg <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        MODE_CONTROL_0_ADDR:  rd_data_reg <= mode_control_reg[0];
        MODE_CONTROL_1_ADDR:  rd_data_reg <= mode_control_reg[1];
        COMPARE_VALUE_0_ADDR: rd_data_reg <= compare_value_reg[0];
        COMPARE_VALUE_1_ADDR: rd_data_reg <= compare_value_reg[1];
        COUNTER_0_ADDR:       rd_data_reg <= counter[0];
        COUNTER_1_ADDR:       rd_data_reg <= counter[1];
        default:              rd_data_reg <= 8'h00;
      endcase
    end
  end

  assign o_rd_data     = rd_data_reg;
  assign o_match_irq_0 = match_irq[0];
  assign o_match_irq_1 = match_irq[1];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_stop_holds_zero: assert property (
    !count_enable[0] |=> counter[0] == 8'h00
  ) else $error("stopped timer 0 counter is not zero");

  a_stop_zero_one: assert property (
    !count_enable[1] |=> counter[1] == 8'h00 && !match_irq[1]
  ) else $error("stopped timer 1 counter not zero or request raised");

  a_div4_phase: assert property (
    count_tick[0] && clock_select[0] == 2'h0 |-> phase[1:0] == 2'h3
  ) else $error("timer 0 fast clock is not main clock over 4");

  a_div64_phase: assert property (
    count_tick[0] && clock_select[0] == 2'h2 |-> phase[5:0] == 6'h3f
  ) else $error("timer 0 slow clock is not main clock over 64");

  a_banned_idle: assert property (
    clock_select[0] == 2'h3 |-> !count_tick[0]
  ) else $error("barred clock select 0 still produced a count clock");

  a_div2_spacing: assert property (
    clock_select[1] == 2'h0 |-> count_tick[1] == phase[0]
  ) else $error("timer 1 fast clock is not main clock over 2");

  a_div128_phase: assert property (
    count_tick[1] && clock_select[1] == 2'h2 |-> phase == 7'h7f
  ) else $error("timer 1 slow clock is not main clock over 128");

  a_match_clears: assert property (
    count_enable[0] && count_tick[0] && counter[0] == compare_value_reg[0]
      |=> counter[0] == 8'h00 && o_match_irq_0
  ) else $error("timer 0 match did not clear and request");

  a_irq_has_cause: assert property (
    o_match_irq_1 |-> $past(count_enable[1] && count_tick[1]
                            && counter[1] == compare_value_reg[1])
  ) else $error("timer 1 request without its own match");

  a_count_step: assert property (
    count_enable[0] && count_tick[0] && counter[0] != compare_value_reg[0]
      |=> counter[0] == $past(counter[0]) + 8'h01 && !o_match_irq_0
  ) else $error("timer 0 did not advance by one per count clock");

  a_count_holds: assert property (
    count_enable[1] && $past(count_enable[1]) && !count_tick[1]
      |=> $stable(counter[1])
  ) else $error("timer 1 moved without a count clock");

  a_compare_load: assert property (
    i_wr && i_addr == COMPARE_VALUE_0_ADDR && i_wr_bits == 8'hff
      |=> compare_value_reg[0] == $past(i_wr_data)
  ) else $error("compare 0 did not take the written byte");

  a_read_count: assert property (
    i_rd && i_addr == COUNTER_1_ADDR |=> o_rd_data == $past(counter[1])
  ) else $error("count read returned the wrong byte");

  a_bit_write: assert property (
    i_wr && i_addr == MODE_CONTROL_0_ADDR && i_wr_bits == 8'h80
      |=> mode_control_reg[0][6:0] == $past(mode_control_reg[0][6:0])
          && count_enable[0] == $past(i_wr_data[7])
  ) else $error("single-bit write disturbed other mode bits");

  a_mode_reserved: assert property (
    (mode_control_reg[0] & ~MODE_WRITABLE_MASK) == 8'h00
  ) else $error("reserved mode control bits are not zero");

  a_irq_pulse: assert property (
    o_match_irq_0 |=> !o_match_irq_0
  ) else $error("timer 0 request wider than one clock");

  a_irq_pulse_one: assert property (
    o_match_irq_1 |=> !o_match_irq_1
  ) else $error("timer 1 request wider than one clock");

  a_banned_idle_one: assert property (
    clock_select[1] == 2'h3 |-> !count_tick[1]
  ) else $error("barred clock select 1 still produced a count clock");

  a_div16_phase: assert property (
    count_tick[0] && clock_select[0] == 2'h1 |-> phase[3:0] == 4'hf
  ) else $error("timer 0 middle clock is not main clock over 16");

  a_div32_phase: assert property (
    count_tick[1] && clock_select[1] == 2'h1 |-> phase[4:0] == 5'h1f
  ) else $error("timer 1 middle clock is not main clock over 32");

  a_match_clears_one: assert property (
    count_enable[1] && count_tick[1] && counter[1] == compare_value_reg[1]
      |=> counter[1] == 8'h00 && o_match_irq_1
  ) else $error("timer 1 match did not clear and request");

  a_count_step_one: assert property (
    count_enable[1] && count_tick[1] && counter[1] != compare_value_reg[1]
      |=> counter[1] == $past(counter[1]) + 8'h01 && !o_match_irq_1
  ) else $error("timer 1 did not advance by one per count clock");

  a_irq_cause_zero: assert property (
    o_match_irq_0 |-> $past(count_enable[0] && count_tick[0]
                            && counter[0] == compare_value_reg[0])
  ) else $error("timer 0 request without its own match");

  a_count_holds_zero: assert property (
    count_enable[0] && $past(count_enable[0]) && !count_tick[0]
      |=> $stable(counter[0])
  ) else $error("timer 0 moved without a count clock");

  a_irq_stop_zero: assert property (
    !count_enable[0] |=> !o_match_irq_0
  ) else $error("stopped timer 0 raised a request");

  a_compare_load_one: assert property (
    i_wr && i_addr == COMPARE_VALUE_1_ADDR && i_wr_bits == 8'hff
      |=> compare_value_reg[1] == $past(i_wr_data)
  ) else $error("compare 1 did not take the written byte");

  a_read_cmp_zero: assert property (
    i_rd && i_addr == COMPARE_VALUE_0_ADDR
      |=> o_rd_data == $past(compare_value_reg[0])
  ) else $error("compare 0 read returned the wrong byte");

  a_read_count_zero: assert property (
    i_rd && i_addr == COUNTER_0_ADDR |=> o_rd_data == $past(counter[0])
  ) else $error("count 0 read returned the wrong byte");

  a_read_mode_one: assert property (
    i_rd && i_addr == MODE_CONTROL_1_ADDR
      |=> o_rd_data == $past(mode_control_reg[1])
  ) else $error("mode control 1 read returned the wrong byte");

  a_mode_reserved_one: assert property (
    (mode_control_reg[1] & ~MODE_WRITABLE_MASK) == 8'h00
  ) else $error("reserved mode control 1 bits are not zero");

  a_bit_write_one: assert property (
    i_wr && i_addr == MODE_CONTROL_1_ADDR && i_wr_bits == 8'h80
      |=> mode_control_reg[1][6:0] == $past(mode_control_reg[1][6:0])
          && count_enable[1] == $past(i_wr_data[7])
  ) else $error("single-bit write disturbed other mode 1 bits");

  c_banned_hold: cover property (
    count_enable[0] && clock_select[0] == 2'h3
  );

  c_match_zero: cover property (
    o_match_irq_0 && compare_value_reg[0] == 8'h00
  );

  c_both_match: cover property (
    o_match_irq_0 && o_match_irq_1
  );

  c_slow_wrap: cover property (
    o_match_irq_1 && clock_select[1] == 2'h2
      && compare_value_reg[1] == 8'hff
  );

  c_bit_enable: cover property (
    i_wr && i_addr == MODE_CONTROL_1_ADDR && i_wr_bits == 8'h80
  );
endmodule // dual_interval_timer
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench
  import itmr_pkg::*;
;
  logic        i_clk;
  logic        i_rst;
  logic [15:0] i_addr;
  logic        i_wr;
  logic [7:0]  i_wr_data;
  logic [7:0]  i_wr_bits;
  logic        i_rd;
  logic [7:0]  o_rd_data;
  logic        o_match_irq_0;
  logic        o_match_irq_1;
  int          failures;
  int          checks;
  int          cycles;
  integer      seed;
  int          gap;
  logic [7:0]  d;

  dual_interval_timer dut (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_addr        (i_addr),
    .i_wr          (i_wr),
    .i_wr_data     (i_wr_data),
    .i_wr_bits     (i_wr_bits),
    .i_rd          (i_rd),
    .o_rd_data     (o_rd_data),
    .o_match_irq_0 (o_match_irq_0),
    .o_match_irq_1 (o_match_irq_1)
  );

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Ceiling well above the longest expected run of some 12000 cycles
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] maddr(input int t);
    return t ? MODE_CONTROL_1_ADDR : MODE_CONTROL_0_ADDR;
  endfunction
  function automatic logic [15:0] caddr(input int t);
    return t ? COMPARE_VALUE_1_ADDR : COMPARE_VALUE_0_ADDR;
  endfunction
  function automatic logic [15:0] naddr(input int t);
    return t ? COUNTER_1_ADDR : COUNTER_0_ADDR;
  endfunction
  function automatic int divider(input int t, input int s);
    int tab0[3] = '{4, 16, 64};
    int tab1[3] = '{2, 32, 128};
    return t ? tab1[s] : tab0[s];
  endfunction
  function automatic logic irq(input int t);
    return t ? o_match_irq_1 : o_match_irq_0;
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] v,
                    input logic [7:0] m);
    i_addr = a;
    i_wr_data = v;
    i_wr_bits = m;
    i_wr = 1'b1;
    @(negedge i_clk);
    i_wr = 1'b0;
    @(negedge i_clk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_clk);
    i_rd = 1'b0;
    @(negedge i_clk);
    v = o_rd_data;
  endtask

  // Counts falling edges until the next request pulse
  task automatic wait_irq(input int t, output int n);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (irq(t) !== 1'b1 && n < 5000);
  endtask

  task automatic run(input int t, input int s, input logic [7:0] cmp);
    int n;
    wr(maddr(t), 8'h00, 8'hff);
    wr(maddr(t), 8'(s << 1), 8'h06);
    wr(caddr(t), cmp, 8'hff);
    rd(caddr(t), d);
    check(d, cmp);
    wr(maddr(t), 8'h80, 8'h80);
    wait_irq(t, n);
    wait_irq(t, n);
    check(n, 32'((cmp + 1) * divider(t, s)));
    // Read launched right at the request sees the cleared count
    rd(naddr(t), d);
    check(d, 8'h00);
    wr(maddr(t), 8'h00, 8'h80);
    @(negedge i_clk);
    rd(naddr(t), d);
    check(d, 8'h00);
    rd(maddr(t), d);
    check(d, 8'(s << 1));
  endtask

  initial begin
    seed = 35;
    failures = 0;
    checks = 0;
    cycles = 0;
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 16'h0000;
    i_wr_data = 8'h00;
    i_wr_bits = 8'h00;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    for (int t = 0; t < 2; t++) begin
      rd(naddr(t), d);
      check(d, 8'h00);
      rd(maddr(t), d);
      check(d, 8'h00);
    end
    rd(16'hff52, d);
    check(d, 8'h00);
    // Select first, then enable on its own; code 11 must not count
    for (int t = 0; t < 2; t++) begin
      wr(maddr(t), 8'hff, 8'h7f);
      rd(maddr(t), d);
      check(d, 8'h06);
      wr(maddr(t), 8'hff, 8'h80);
      repeat (300) @(negedge i_clk);
      rd(naddr(t), d);
      check(d, 8'h00);
      rd(maddr(t), d);
      check(d, 8'h86);
      wr(maddr(t), 8'h00, 8'h80);
      rd(maddr(t), d);
      check(d, 8'h06);
      wr(maddr(t), 8'h00, 8'hff);
    end
    // Clock codes 00 to 10 of both timers, compare 00 on code 00, the FF corner after
    for (int t = 0; t < 2; t++) begin
      for (int s = 0; s < 3; s++) begin
        run(t, s, (s == 0) ? 8'h00 : 8'($random(seed) & 15));
      end
    end
    run(0, 0, 8'hff);
    // Timer 0 keeps running on /16 while timer 1 is exercised
    wr(maddr(0), 8'h00, 8'hff);
    wr(maddr(0), 8'h02, 8'h06);
    wr(caddr(0), 8'h07, 8'hff);
    wr(maddr(0), 8'h80, 8'h80);
    run(1, 0, 8'($random(seed)));
    wait_irq(0, gap);
    wait_irq(0, gap);
    check(gap, 32'(8 * divider(0, 1)));
    test_done();
  end
endmodule // testbench
`default_nettype wire
